// [verilog/adc_conversion_sequencer.sv]
// conversion sequencer: registers, start, abort, sleep and trigger control
// assumes Avalon-MM master on clk; trigger and sleep inputs on clk;
// rc tick and comparator come from outside the clock domain
// Function
// - converter stays off until enable written
// - start write clears results, then converts
// - completion clears start, sets done flag
// - clearing start aborts, partial result kept
// - bits shift in from low end
// - unsigned format inserts at low bit 4
// - reset returns all registers to defaults
// - only rc clock converts through sleep
// - rc clock delays start one instruction
// - sleep completion with irq enable wakes
// - sleep completion without irq powers down
// - other clock: sleep aborts, powers down
// - trigger edge sets start, resets timer
// - four-bit field selects trigger source
// - reserved channel codes connect nothing
// - conversion lasts fifteen bit periods
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
module adc_conversion_sequencer
    import adc_seq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // avalon-mm slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // trigger sources and timer
    input wire logic [3:0] trig_src,
    output logic timer_reset,
    // power manager
    input wire logic sleep_in,
    output logic wake_req,
    // analog front end
    input wire logic frc_clk_in,
    input wire logic cmp_in,
    output logic converter_power,
    output logic converting,
    output logic [4:0] channel_sel,
    output logic channel_connect,
    output logic ref_buf1_route,
    output logic done_flag
);
    logic rst_s1_ff;
    logic srst_n;
    logic frc_s1_ff;
    logic frc_s2_ff;
    logic frc_s3_ff;
    logic cmp_s1_ff;
    logic cmp_s2_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;
    logic en_ff;
    logic go_ff;
    logic [4:0] chs_ff;
    logic [2:0] cs_ff;
    logic fm_ff;
    logic [3:0] tsel_ff;
    logic [3:0] nch_ff;
    logic [7:0] resh_ff;
    logic [7:0] resl_ff;
    logic flag_ff;
    logic ie_ff;
    logic pd_ff;
    logic trig_prev_ff;
    logic timer_reset_ff;
    logic wake_ff;
    logic start_ff;
    logic [2:0] dly_ff;
    seq_e seq_ff;
    seq_e nxt_seq;
    logic [4:0] chs_out_ff;
    logic connect_ff;
    logic ref_ff;
    logic power_ff;
    sar_if sar ();

    ////////////////////////////////////////////////////////////////////
    // reset release through two flops
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_s1_ff <= 1'b0;
            srst_n <= 1'b0;
        end
        else
        begin
            rst_s1_ff <= 1'b1;
            srst_n <= rst_s1_ff;
        end
    end

    // rc clock and comparator come from outside, two flops first
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            frc_s1_ff <= 1'b0;
            frc_s2_ff <= 1'b0;
            frc_s3_ff <= 1'b0;
            cmp_s1_ff <= 1'b0;
            cmp_s2_ff <= 1'b0;
        end
        else
        begin
            frc_s1_ff <= frc_clk_in;
            frc_s2_ff <= frc_s1_ff;
            frc_s3_ff <= frc_s2_ff;
            cmp_s1_ff <= cmp_in;
            cmp_s2_ff <= cmp_s1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus decode; every access takes exactly one wait cycle
    logic req_w;
    logic wr_w;
    logic wr_c0;
    logic wr_c1;
    logic wr_c2;
    logic wr_st;
    logic [31:0] rd_mux;
    assign req_w = read || write;
    assign wr_w = write && !wait_ff;
    assign wr_c0 = wr_w && (address == OFS_CTRL0);
    assign wr_c1 = wr_w && (address == OFS_CTRL1);
    assign wr_c2 = wr_w && (address == OFS_CTRL2);
    assign wr_st = wr_w && (address == OFS_STAT);
    assign rd_mux = (address == OFS_CTRL0) ? {24'h0, 1'b0, chs_ff, go_ff, en_ff} :
                    (address == OFS_CTRL1) ? {24'h0, fm_ff, 4'h0, cs_ff} :
                    (address == OFS_CTRL2) ? {24'h0, nch_ff, tsel_ff} :
                    (address == OFS_RESH) ? {24'h0, resh_ff} :
                    (address == OFS_RESL) ? {24'h0, resl_ff} :
                    (address == OFS_STAT) ? {30'h0, ie_ff, flag_ff} : 32'h0;

    // answer one cycle after the request appears
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0;
        end
        else
        begin
            wait_ff <= !(req_w && wait_ff);
            if (read && wait_ff)
                rdata_ff <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // start, abort and trigger conditions
    logic frc_w;
    logic trig_sel_w;
    logic trig_rise_w;
    logic live_w;
    logic start_req;
    logic sleep_abort;
    logic abort_w;
    logic finish_w;
    assign frc_w = is_frc(cs_ff);
    assign trig_sel_w = (tsel_ff == TSEL_CMP_A) ? trig_src[0] :
                        (tsel_ff == TSEL_CMP_B) ? trig_src[1] :
                        (tsel_ff == TSEL_PWM_A) ? trig_src[2] :
                        (tsel_ff == TSEL_PWM_B) ? trig_src[3] : 1'b0;
    assign trig_rise_w = trig_sel_w && !trig_prev_ff;
    // old enable value gates start, so a combined write does not start
    assign live_w = en_ff && !pd_ff && !go_ff;
    assign start_req = live_w && ((wr_c0 && writedata[GO_BIT]) || trig_rise_w);
    assign sleep_abort = sleep_in && !frc_w;
    assign abort_w = go_ff && ((wr_c0 && !writedata[GO_BIT])
                     || (wr_c0 && !writedata[EN_BIT]) || sleep_abort);
    assign finish_w = sar.done && go_ff;

    // control register 0
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            en_ff <= 1'b0;
            go_ff <= 1'b0;
            chs_ff <= CHS_RST;
        end
        else
        begin
            if (wr_c0)
            begin
                en_ff <= writedata[EN_BIT];
                chs_ff <= writedata[CHS_LSB +: 5];
            end
            if (start_req)
                go_ff <= 1'b1;
            else if (finish_w || abort_w)
                go_ff <= 1'b0;
        end
    end

    // control 1, control 2, status
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            cs_ff <= CS_RST;
            fm_ff <= 1'b0;
            tsel_ff <= NIB_RST;
            nch_ff <= NIB_RST;
            ie_ff <= 1'b0;
        end
        else
        begin
            if (wr_c1)
            begin
                cs_ff <= writedata[CS_LSB +: 3];
                fm_ff <= writedata[FM_BIT];
            end
            if (wr_c2)
            begin
                tsel_ff <= writedata[TSEL_LSB +: 4];
                nch_ff <= writedata[NCH_LSB +: 4];
            end
            if (wr_st)
                ie_ff <= writedata[IE_BIT];
        end
    end

    // done flag: completion wins over a write-one clear
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
            flag_ff <= 1'b0;
        else if (finish_w)
            flag_ff <= 1'b1;
        else if (wr_st && writedata[FLAG_BIT])
            flag_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // result shift; unsigned format keeps the low nibble zero
    logic [11:0] res_cur;
    logic [11:0] res_new;
    assign res_cur = fm_ff ? {resh_ff[3:0], resl_ff} : {resh_ff, resl_ff[7:4]};
    assign res_new = {res_cur[10:0], sar.bit_val};
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            resh_ff <= CTRL_RST;
            resl_ff <= CTRL_RST;
        end
        else if (start_req)
        begin
            resh_ff <= CTRL_RST;
            resl_ff <= CTRL_RST;
        end
        else if (sar.bit_valid && go_ff && !abort_w)
        begin
            resh_ff <= fm_ff ? {4'h0, res_new[11:8]} : res_new[11:4];
            resl_ff <= fm_ff ? res_new[7:0] : {res_new[3:0], 4'h0};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequence: rc clock waits one instruction before the engine starts
    logic dly_end;
    assign dly_end = (dly_ff == INSTR_CLKS - 3'h1);
    always_comb
    begin
        nxt_seq = seq_ff;
        case (seq_ff)
            SEQ_IDLE: if (start_req) nxt_seq = frc_w ? SEQ_DELAY : SEQ_CONV;
            SEQ_DELAY: if (abort_w) nxt_seq = SEQ_IDLE;
                       else if (dly_end) nxt_seq = SEQ_CONV;
            SEQ_CONV: if (abort_w || finish_w) nxt_seq = SEQ_IDLE;
            default: nxt_seq = SEQ_IDLE;
        endcase
    end

    // state, delay count and engine start strobe
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            seq_ff <= SEQ_IDLE;
            dly_ff <= 3'h0;
            start_ff <= 1'b0;
        end
        else
        begin
            seq_ff <= nxt_seq;
            dly_ff <= (seq_ff == SEQ_DELAY) ? dly_ff + 3'h1 : 3'h0;
            start_ff <= (seq_ff == SEQ_IDLE && start_req && !frc_w) ||
                        (seq_ff == SEQ_DELAY && dly_end && !abort_w);
        end
    end

    assign sar.start = start_ff;
    assign sar.abort = abort_w;
    assign sar.cs = cs_ff;
    assign sar.frc_tick = frc_s2_ff && !frc_s3_ff;
    assign sar.cmp_bit = cmp_s2_ff;
    sar_engine u_engine (
        .clk(clk),
        .srst_n(srst_n),
        .sar(sar.engine)
    );

    ////////////////////////////////////////////////////////////////////
    // sleep power-down, wake and trigger timer reset
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            pd_ff <= 1'b0;
            wake_ff <= 1'b0;
            trig_prev_ff <= 1'b0;
            timer_reset_ff <= 1'b0;
        end
        else
        begin
            if (!sleep_in)
                pd_ff <= 1'b0;
            else if (sleep_abort || (finish_w && !ie_ff))
                pd_ff <= 1'b1;
            wake_ff <= finish_w && sleep_in && ie_ff;
            trig_prev_ff <= trig_sel_w;
            timer_reset_ff <= trig_rise_w;
        end
    end

    // analog side controls from flops
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            chs_out_ff <= CHS_RST;
            connect_ff <= 1'b0;
            ref_ff <= 1'b0;
            power_ff <= 1'b0;
        end
        else
        begin
            chs_out_ff <= chs_ff;
            connect_ff <= en_ff && chan_ok(chs_ff);
            ref_ff <= en_ff && (chs_ff == CHS_REF_BUF1);
            power_ff <= en_ff && !pd_ff;
        end
    end

    assign readdata = rdata_ff;
    assign waitrequest = wait_ff;
    assign timer_reset = timer_reset_ff;
    assign wake_req = wake_ff;
    assign converter_power = power_ff;
    assign converting = go_ff;
    assign channel_sel = chs_out_ff;
    assign channel_connect = connect_ff;
    assign ref_buf1_route = ref_ff;
    assign done_flag = flag_ff;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!srst_n);

    property p_go_needs_en;
        go_ff |-> en_ff;
    endproperty
    a_go_needs_en: assert property (p_go_needs_en) else $error("start set while off");

    property p_start_clears;
        start_req |=> (resh_ff == 8'h00) && (resl_ff == 8'h00) && go_ff;
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("results not cleared");

    property p_finish;
        finish_w && !start_req |=> !go_ff && flag_ff && seq_ff == SEQ_IDLE;
    endproperty
    a_finish: assert property (p_finish) else $error("completion not flagged");

    property p_abort_keeps;
        abort_w && !start_req |=> !go_ff && $stable(resh_ff) && $stable(resl_ff);
    endproperty
    a_abort_keeps: assert property (p_abort_keeps) else $error("abort lost result");

    property p_shift_low;
        sar.bit_valid && go_ff && !abort_w && !start_req && !fm_ff
            |=> resl_ff[4] == $past(sar.bit_val) && resl_ff[3:0] == 4'h0;
    endproperty
    a_shift_low: assert property (p_shift_low) else $error("bit not at low bit 4");

    property p_frc_delay;
        seq_ff == SEQ_IDLE && start_req && frc_w ##1 (go_ff && frc_w)[*4] |=> start_ff;
    endproperty
    a_frc_delay: assert property (p_frc_delay) else $error("rc start not delayed");

    property p_frc_no_early;
        seq_ff == SEQ_IDLE && start_req && frc_w |=> !start_ff [*4];
    endproperty
    a_frc_no_early: assert property (p_frc_no_early) else $error("rc start too early");

    property p_sleep_abort;
        go_ff && sleep_in && !frc_w |=> !go_ff && pd_ff ##1 !converter_power;
    endproperty
    a_sleep_abort: assert property (p_sleep_abort) else $error("sleep did not abort");

    property p_wake;
        finish_w && sleep_in && ie_ff |=> wake_req;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on completion");

    property p_sleep_off;
        finish_w && sleep_in && !ie_ff && !wr_c0 |=> pd_ff && en_ff;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("no power-down after sleep");

    property p_trig;
        trig_rise_w && live_w |=> timer_reset && go_ff;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger edge missed");

    property p_reserved;
        !chan_ok(chs_ff) |=> !channel_connect;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code connected");

    property p_idle_zero;
        wr_c0 && !writedata[GO_BIT] && !go_ff && !start_req
            |=> $stable(resh_ff) && $stable(resl_ff) && $stable(flag_ff);
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("idle zero write acted");

    c_finish: cover property (finish_w);
    c_abort: cover property (abort_w && seq_ff == SEQ_CONV);
    c_trig_start: cover property (trig_rise_w && live_w);
    c_sleep_wake: cover property (finish_w && sleep_in && ie_ff);
endmodule : adc_conversion_sequencer

// [verilog/adc_seq_pkg.sv]
// constants, field layout and helpers of the conversion sequencer
// assumes a 200 MHz system clock and a 32-bit word-aligned register bus
package adc_seq_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_CTRL2 = 8'h08;
    localparam logic [7:0] OFS_RESH = 8'h0C;
    localparam logic [7:0] OFS_RESL = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    // field positions
    localparam int EN_BIT = 0;
    localparam int GO_BIT = 1;
    localparam int CHS_LSB = 2;
    localparam int CS_LSB = 0;
    localparam int FM_BIT = 7;
    localparam int TSEL_LSB = 0;
    localparam int NCH_LSB = 4;
    localparam int FLAG_BIT = 0;
    localparam int IE_BIT = 1;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [4:0] CHS_RST = 5'h00;
    localparam logic [3:0] NIB_RST = 4'h0;
    localparam logic [2:0] CS_RST = 3'h0;
    // channel codes and trigger source codes
    localparam logic [4:0] CHS_REF_BUF1 = 5'h1F;
    localparam logic [3:0] TSEL_CMP_A = 4'h1;
    localparam logic [3:0] TSEL_CMP_B = 4'h2;
    localparam logic [3:0] TSEL_PWM_A = 4'h3;
    localparam logic [3:0] TSEL_PWM_B = 4'h4;
    // conversion timing
    localparam logic [3:0] TAD_PER_CONV = 4'hF;
    localparam logic [3:0] TAD_FIRST_BIT = 4'h2;
    localparam logic [3:0] TAD_LAST_BIT = 4'hD;
    localparam int CLK_NS = 5;
    localparam int INSTR_NS = 20;
    localparam logic [2:0] INSTR_CLKS = 3'((INSTR_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [1:0] {SEQ_IDLE = 2'b00, SEQ_DELAY = 2'b01, SEQ_CONV = 2'b11} seq_e;

    // system clocks per bit period for each clock select code
    function automatic logic [6:0] tad_clocks(input logic [2:0] cs);
        case (cs)
            3'h0: tad_clocks = 7'h02;
            3'h4: tad_clocks = 7'h04;
            3'h1: tad_clocks = 7'h08;
            3'h5: tad_clocks = 7'h10;
            3'h2: tad_clocks = 7'h20;
            3'h6: tad_clocks = 7'h40;
            default: tad_clocks = 7'h02;
        endcase
    endfunction : tad_clocks

    function automatic logic is_frc(input logic [2:0] cs);
        is_frc = (cs[1:0] == 2'h3);
    endfunction : is_frc

    // codes that reach a real input
    function automatic logic chan_ok(input logic [4:0] c);
        chan_ok = (c <= 5'h04) || (c >= 5'h08 && c <= 5'h0D) || (c >= 5'h1D);
    endfunction : chan_ok
endpackage : adc_seq_pkg

// [verilog/sar_if.sv]
// signals between the sequencer and its bit-timing engine
// assumes both ends share one clock
interface sar_if;
    logic start;
    logic abort;
    logic [2:0] cs;
    logic frc_tick;
    logic cmp_bit;
    logic busy;
    logic bit_valid;
    logic bit_val;
    logic done;
    modport engine (input start, abort, cs, frc_tick, cmp_bit,
                    output busy, bit_valid, bit_val, done);
    modport ctrl (output start, abort, cs, frc_tick, cmp_bit,
                  input busy, bit_valid, bit_val, done);
endinterface : sar_if

// [verilog/sar_engine.sv]
// bit-period timing and per-bit strobes of one conversion
// assumes an active-low reset released in step with clk and a synchronised rc tick
module sar_engine
    import adc_seq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst_n,
    // sequencer side
    sar_if.engine sar
);
    logic [6:0] div_ff;
    logic [3:0] tad_ff;
    logic busy_ff;
    logic bit_valid_ff;
    logic bit_val_ff;
    logic done_ff;
    logic tick_w;
    logic last_w;
    logic bit_w;

    ////////////////////////////////////////////////////////////////////
    // bit period tick: rc edge or divided system clock
    assign tick_w = is_frc(sar.cs) ? sar.frc_tick
                                   : (div_ff == tad_clocks(sar.cs) - 7'h01);
    assign last_w = (tad_ff == TAD_PER_CONV - 4'h1);
    assign bit_w = (tad_ff >= TAD_FIRST_BIT) && (tad_ff <= TAD_LAST_BIT);

    // divider and period counter restart at each start
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            div_ff <= 7'h00;
            tad_ff <= 4'h0;
            busy_ff <= 1'b0;
        end
        else if (sar.start)
        begin
            div_ff <= 7'h00;
            tad_ff <= 4'h0;
            busy_ff <= 1'b1;
        end
        else if (sar.abort)
            busy_ff <= 1'b0;
        else if (busy_ff)
        begin
            div_ff <= tick_w ? 7'h00 : div_ff + 7'h01;
            if (tick_w)
            begin
                tad_ff <= tad_ff + 4'h1;
                busy_ff <= !last_w;
            end
        end
    end

    // one-cycle strobes
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            bit_valid_ff <= 1'b0;
            bit_val_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            bit_valid_ff <= busy_ff && tick_w && bit_w && !sar.abort && !sar.start;
            bit_val_ff <= sar.cmp_bit;
            done_ff <= busy_ff && tick_w && last_w && !sar.abort && !sar.start;
        end
    end

    assign sar.busy = busy_ff;
    assign sar.bit_valid = bit_valid_ff;
    assign sar.bit_val = bit_val_ff;
    assign sar.done = done_ff;
endmodule : sar_engine

// [dv/testbench.sv]
// self-checking bench of the conversion sequencer: bus tasks, table, hand-written cases
// assumes the design's assertions sit in its own files; rc clock runs free
module testbench
    import adc_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0;
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h0;
    logic [3:0] trig_src = 4'h0;
    logic sleep_in = 1'b0, frc_clk_in = 1'b0, cmp_in = 1'b1;
    logic [31:0] readdata;
    logic [4:0] channel_sel;
    logic waitrequest, timer_reset, wake_req, converter_power, converting;
    logic channel_connect, ref_buf1_route, done_flag, wake_seen = 1'b0;
    int err_count = 0, n_checks = 0, cycles = 0, n, k;
    logic [7:0] q, h;
    // control 0 rows: write, readback, {power, connect, route}
    logic [7:0] row_w[4] = '{8'h7E, 8'hFF, 8'h1D, 8'h81};
    logic [7:0] row_r[4] = '{8'h7C, 8'h7D, 8'h1D, 8'h01};
    logic [2:0] row_o[4] = '{3'h0, 3'h7, 3'h4, 3'h6};
    ////////////////////////////////////////////////////////////////////////////////
    adc_conversion_sequencer i_adc_conversion_sequencer (.clk(clk), .rstn(rstn),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .trig_src(trig_src),
        .timer_reset(timer_reset), .sleep_in(sleep_in), .wake_req(wake_req),
        .frc_clk_in(frc_clk_in), .cmp_in(cmp_in), .converter_power(converter_power),
        .converting(converting), .channel_sel(channel_sel),
        .channel_connect(channel_connect), .ref_buf1_route(ref_buf1_route),
        .done_flag(done_flag));
    // system clock, free-running rc oscillator unrelated in phase
    always #2.5 clk = ~clk;
    always #23 frc_clk_in = ~frc_clk_in;
    // hang guard sized for under 1k cycles of tests
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_count = err_count + 1;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // one avalon access; request held until waitrequest low is seen at an edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] rd);
        int t;
        t = 0;
        @(posedge clk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= {24'h0, d};
        do
        begin
            @(posedge clk);
            t = t + 1;
        end
        while (waitrequest !== 1'b0 && t < 50);
        rd = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        check("bus_answer", 16'(t < 50), 16'h1);
        // one more edge so that callers see the settled effect of the access
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        bus(1'b0, a, 8'h00, d);
    endtask : rd
    // bounded wait for the busy bit to drop; n holds the cycles taken
    // wake pulse is one cycle wide and comes with the busy drop, so latch it here
    task automatic wait_idle(input int lim);
        n = 0;
        do
        begin
            @(negedge clk);
            n = n + 1;
            if (wake_req === 1'b1) wake_seen = 1'b1;
        end
        while (converting !== 1'b0 && n < lim);
    endtask : wait_idle
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        for (k = 0; k < 6; k++)
        begin
            rd(8'(4 * k), q);
            check("reset_value", q, 0);
        end
        rd(8'h1C, q);
        check("unmapped_read", q, 0);
        for (k = 0; k < 4; k++)
        begin
            wr(OFS_CTRL0, row_w[k]);
            rd(OFS_CTRL0, q);
            check("ctrl0_readback", q, row_r[k]);
            check("chan_sel", channel_sel, row_w[k][6:2]);
            check("pwr_conn_route", {converter_power, channel_connect, ref_buf1_route},
                row_o[k]);
            check("no_start_with_enable", converting, 0);
        end
        // full conversion at /2, comparator always high
        wr(OFS_CTRL0, 8'h03);
        check("busy_after_start", converting, 1);
        wait_idle(200);
        check("conv_length", 16'(n >= 29 && n <= 34), 1);
        check("done_flag_set", done_flag, 1);
        rd(OFS_CTRL0, q);
        check("start_cleared", q, 8'h01);
        rd(OFS_RESH, q);
        check("res_high_full", q, 8'hFF);
        rd(OFS_RESL, q);
        check("res_low_full", q, 8'hF0);
        wr(OFS_CTRL0, 8'h01);
        check("idle_zero_flag", done_flag, 1);
        rd(OFS_RESH, q);
        check("idle_zero_res", q, 8'hFF);
        wr(OFS_STAT, 8'h01);
        check("flag_cleared", done_flag, 0);
        // abort in mid-conversion keeps a partial all-ones value from the low end
        wr(OFS_CTRL0, 8'h03);
        repeat (12) @(posedge clk);
        wr(OFS_CTRL0, 8'h01);
        repeat (4) @(posedge clk);
        check("aborted", {converting, done_flag}, 0);
        rd(OFS_RESH, h);
        rd(OFS_RESL, q);
        check("partial_shape", 16'((({h, q[7:4]} + 12'h1) & {h, q[7:4]}) == 0
            && h != 8'hFF && q[4]), 1);
        // trigger codes: 0 selects nothing, 1..4 one source each
        for (k = 0; k < 5; k++)
        begin
            wr(OFS_CTRL2, 8'(k));
            @(posedge clk);
            trig_src <= (k == 0) ? 4'h1 : 4'(1 << (k - 1));
            n = 0;
            repeat (8)
            begin
                @(negedge clk);
                if (timer_reset === 1'b1) n = 1;
            end
            check("timer_reset", 16'(n), 16'(k != 0));
            check("trig_start", converting, 16'(k != 0));
            @(posedge clk);
            trig_src <= 4'h0;
            wr(OFS_CTRL0, 8'h01);
        end
        wr(OFS_CTRL2, 8'h00);
        // twos-complement format: twelve ones right aligned
        wr(OFS_CTRL1, 8'h80);
        wr(OFS_CTRL0, 8'h03);
        wait_idle(200);
        rd(OFS_RESH, h);
        rd(OFS_RESL, q);
        check("twos_result", {h, q}, 16'h0FFF);
        wr(OFS_STAT, 8'h01);
        // sleep with a system-derived clock aborts and powers down, enable kept
        wr(OFS_CTRL0, 8'h03);
        sleep_in <= 1'b1;
        repeat (6) @(posedge clk);
        check("sleep_abort", {converting, converter_power, done_flag}, 0);
        rd(OFS_CTRL0, q);
        check("sleep_en_kept", q, 8'h01);
        sleep_in <= 1'b0;
        // rc clock converts through sleep; wake with irq on, power down with it off
        wr(OFS_CTRL1, 8'h03);
        for (k = 1; k >= 0; k--)
        begin
            wr(OFS_STAT, {6'h0, k[0], 1'b1});
            wake_seen = 1'b0;
            wr(OFS_CTRL0, 8'h03);
            sleep_in <= 1'b1;
            wait_idle(400);
            repeat (3) @(posedge clk);
            check("rc_sleep_done", {done_flag, wake_seen}, {1'b1, k[0]});
            check("rc_power", converter_power, 16'(k));
            rd(OFS_CTRL0, q);
            check("rc_en_kept", q, 8'h01);
            sleep_in <= 1'b0;
        end
        // reset in mid-run cancels the conversion and clears registers
        wr(OFS_CTRL1, 8'h00);
        wr(OFS_CTRL0, 8'h03);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        check("reset_cancel", {converting, converter_power, done_flag}, 0);
        rd(OFS_CTRL0, q);
        check("reset_ctrl0", q, 0);
        give_verdict();
    end
endmodule : testbench
